// *** fdd_addr_map.sv ***
// destination code to on-chip ram start address decoder
// assumes a static code; purely combinational
`timescale 1ns/100ps
`include "fdd_regs.svh"

module fdd_addr_map (
    // destination code
    input wire logic [6:0] code,
    // decoded start address and range check
    output logic [23:0] addr,
    output logic valid
);

    assign valid = (code <= `FDD_CODE_MAX);

    always_comb begin
        case (code)
            7'h00: addr = `FDD_ADDR_C0;
            7'h01: addr = `FDD_ADDR_C1;
            7'h02: addr = `FDD_ADDR_C2;
            7'h03: addr = `FDD_ADDR_C3;
            7'h04: addr = `FDD_ADDR_C4;
            7'h05: addr = `FDD_ADDR_C5;
            7'h06: addr = `FDD_ADDR_C6;
            7'h07: addr = `FDD_ADDR_C7;
            default: addr = 24'h000000; // out of range, never used
        endcase
    end

endmodule

// *** fdd_pkg.sv ***
// types shared by the download destination block
// sets the state encodings itself; other numeric constants are in fdd_regs.svh
package fdd_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        FDD_IDLE  = 3'b001,
        FDD_CHECK = 3'b010,
        FDD_RUN   = 3'b100
    } fdd_state_type;

    // request towards the copy engine
    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
    } fdd_dl_req_type;

    // download destination register layout
    typedef struct packed {
        logic       err;
        logic [6:0] code;
    } fdd_dest_type;

endpackage

// *** fdd_regs.svh ***
// register offsets, field positions, reset values and destination constants
// of the download destination block; definitions only
`ifndef FDD_REGS_SVH
`define FDD_REGS_SVH

// register byte offsets on the apb bus
`define FDD_OFS_DEST     12'h000
`define FDD_OFS_KEY      12'h004
`define FDD_OFS_CTRL     12'h008
`define FDD_OFS_STATUS   12'h00C
`define FDD_OFS_CLEAR    12'h010
`define FDD_OFS_ENABLE   12'h014
`define FDD_OFS_ADDR     12'h018

// field positions
`define FDD_DEST_ERR_BIT 7
`define FDD_CTRL_START   0
`define FDD_EV_DONE      0
`define FDD_EV_ERR       1

// reset values
`define FDD_DEST_RESET   8'h00
`define FDD_KEY_RESET    8'h00
`define FDD_EV_RESET     2'h0

// key and destination code range
`define FDD_KEY_START    8'hA5
`define FDD_CODE_MAX     7'h07

// download start addresses per destination code
`define FDD_ADDR_C0      24'hFF9000
`define FDD_ADDR_C1      24'hFFA000
`define FDD_ADDR_C2      24'hFFB000
`define FDD_ADDR_C3      24'hFFC000
`define FDD_ADDR_C4      24'hFFD000
`define FDD_ADDR_C5      24'hFFE000
`define FDD_ADDR_C6      24'hFF8000
`define FDD_ADDR_C7      24'hFF7000

`endif

// *** fdd_top.sv ***
// download destination select block with apb register slave
// assumes a copy engine on mclk that takes dl_req and answers dl_done
`timescale 1ns/100ps
`include "fdd_regs.svh"

module fdd_top
    import fdd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // copy engine
    output fdd_dl_req_type dl_req,
    input wire logic dl_done,
    // interrupt
    output logic irq
);

    // register state
    fdd_dest_type dest, next_dest;
    logic [7:0] key, next_key;
    logic [1:0] ev_status, next_ev_status;
    logic [1:0] ev_enable, next_ev_enable;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // sequencer state
    fdd_state_type state, next_state;
    fdd_dl_req_type next_dl_req;
    logic [23:0] last_addr, next_last_addr;

    // decoded strobes
    logic access, wr_fire, rd_phase, start_req, start_ok;
    logic hw_set_err, ev_done, ev_err;
    logic [23:0] map_addr;
    logic map_valid;
    logic mapped;

    // code decoder
    fdd_addr_map u_map (
        .code  (dest.code),
        .addr  (map_addr),
        .valid (map_valid)
    );

    // one wait state: read data captured in first access cycle, answered next; writes land in the answered cycle
    assign access = psel & penable;
    assign rd_phase = access & ~pready;
    assign wr_fire = access & pready & pwrite & ~pslverr;

    // address decode
    always_comb begin
        case (paddr)
            `FDD_OFS_DEST, `FDD_OFS_KEY, `FDD_OFS_CTRL, `FDD_OFS_STATUS,
            `FDD_OFS_CLEAR, `FDD_OFS_ENABLE, `FDD_OFS_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign start_req = wr_fire & (paddr == `FDD_OFS_CTRL)
                       & pwdata[`FDD_CTRL_START];
    assign start_ok = start_req & (key == `FDD_KEY_START)
                      & (state == FDD_IDLE);

    // sequencer next state
    always_comb begin
        next_state = state;
        next_dl_req = dl_req;
        next_last_addr = last_addr;
        hw_set_err = 1'b0;
        ev_done = 1'b0;
        ev_err = 1'b0;
        case (state)
            FDD_IDLE: begin
                if (start_ok) begin
                    next_state = FDD_CHECK;
                end
            end
            FDD_CHECK: begin
                if (map_valid) begin
                    next_state = FDD_RUN;
                    next_dl_req.valid = 1'b1;
                    next_dl_req.addr = map_addr;
                    next_last_addr = map_addr;
                end else begin
                    next_state = FDD_IDLE;
                    hw_set_err = 1'b1;
                    ev_err = 1'b1;
                end
            end
            FDD_RUN: begin
                if (dl_done) begin
                    next_state = FDD_IDLE;
                    next_dl_req.valid = 1'b0;
                    ev_done = 1'b1;
                end
            end
            default: begin
                next_state = FDD_IDLE;
                next_dl_req.valid = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FDD_IDLE;
            dl_req <= '0;
            last_addr <= 24'h000000;
        end else begin
            state <= next_state;
            dl_req <= next_dl_req;
            last_addr <= next_last_addr;
        end
    end

    // register file next values
    always_comb begin
        next_dest = dest;
        next_key = key;
        next_ev_status = ev_status;
        next_ev_enable = ev_enable;
        next_prdata = prdata;
        next_pready = rd_phase;
        next_pslverr = rd_phase & ~mapped;
        // software writes; code stays locked while a download runs
        if (wr_fire) begin
            case (paddr)
                `FDD_OFS_DEST: begin
                    if (state == FDD_IDLE) begin
                        next_dest = pwdata[7:0];
                    end
                end
                `FDD_OFS_KEY: next_key = pwdata[7:0];
                `FDD_OFS_CLEAR: next_ev_status = ev_status & ~pwdata[1:0];
                `FDD_OFS_ENABLE: next_ev_enable = pwdata[1:0];
                default: begin
                end
            endcase
        end
        // hardware set wins over software write
        if (hw_set_err) begin
            next_dest.err = 1'b1;
        end
        // events are sticky; set wins over clear
        if (ev_done) begin
            next_ev_status[`FDD_EV_DONE] = 1'b1;
        end
        if (ev_err) begin
            next_ev_status[`FDD_EV_ERR] = 1'b1;
        end
        // read data captured in first access cycle
        if (rd_phase) begin
            case (paddr)
                `FDD_OFS_DEST: next_prdata = {24'h000000, dest};
                `FDD_OFS_KEY: next_prdata = {24'h000000, key};
                `FDD_OFS_CTRL:
                    next_prdata = {31'h00000000, (state != FDD_IDLE)};
                `FDD_OFS_STATUS: next_prdata = {30'h00000000, ev_status};
                `FDD_OFS_ENABLE: next_prdata = {30'h00000000, ev_enable};
                `FDD_OFS_ADDR: next_prdata = {8'h00, last_addr};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // register file flops
    // destination resets to zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dest <= `FDD_DEST_RESET;
            key <= `FDD_KEY_RESET;
            ev_status <= `FDD_EV_RESET;
            ev_enable <= `FDD_EV_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            dest <= next_dest;
            key <= next_key;
            ev_status <= next_ev_status;
            ev_enable <= next_ev_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // level interrupt from enabled sticky events
    assign irq = |(ev_status & ev_enable);

endmodule

// *** fdd_top_props.sv ***
// concurrent checks of the download destination block
// sees only fdd_top ports; shadows key and code from apb writes
`timescale 1ns/100ps
`include "fdd_regs.svh"
module fdd_top_props
    import fdd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // copy engine and interrupt
    input wire fdd_dl_req_type dl_req,
    input wire logic irq
);
    logic [6:0] code_q;
    logic [7:0] key_q;
    logic wr_ok;
    logic start;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    assign wr_ok = psel && penable && pready && pwrite;
    assign start = wr_ok && paddr == `FDD_OFS_CTRL
        && pwdata[`FDD_CTRL_START] && !dl_req.valid;
    // code shadow follows writes while dl_req.valid is low (idle or check), dest writes land only in idle;
    // key writes land in any state, so its shadow must not be gated
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= 7'h00;
            key_q <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == `FDD_OFS_DEST && !dl_req.valid) begin
                code_q <= pwdata[6:0];
            end
            if (paddr == `FDD_OFS_KEY) begin
                key_q <= pwdata[7:0];
            end
        end
    end
    property p_good;
        start && key_q == 8'hA5 && code_q <= 7'h07 |-> ##2 dl_req.valid;
    endproperty
    a_good: assert property (p_good) else $error("no start");
    property p_bad;
        start && key_q == 8'hA5 && code_q > 7'h07 |=> !dl_req.valid [*4];
    endproperty
    a_bad: assert property (p_bad) else $error("bad code ran");
    property p_key;
        start && key_q != 8'hA5 |=> !dl_req.valid [*3];
    endproperty
    a_key: assert property (p_key) else $error("ran unkeyed");
    property p_low;
        $rose(dl_req.valid) && code_q < 7'h02 |->
            dl_req.addr == (code_q[0] ? 24'hFFA000 : 24'hFF9000);
    endproperty
    a_low: assert property (p_low) else $error("low addr");
    property p_high;
        $rose(dl_req.valid) && code_q >= 7'h02 |-> code_q <= 7'h07 &&
            dl_req.addr == (code_q == 7'h06 ? 24'hFF8000 :
            code_q == 7'h07 ? 24'hFF7000 : 24'hFF9000 + {code_q, 12'h000});
    endproperty
    a_high: assert property (p_high) else $error("high addr");
    property p_step;
        dl_req.valid |-> dl_req.addr[11:0] == 12'h000 ##1
            (dl_req.valid -> $stable(dl_req.addr));
    endproperty
    a_step: assert property (p_step) else $error("addr moved");
    property p_rst;
        !$past(rst_n) |-> !dl_req.valid && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule

bind fdd_top fdd_top_props u_props (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .dl_req(dl_req), .irq(irq));

// *** fdd_top_tb.sv ***
// self-checking bench of the download destination block
// assumes fdd_top answers apb with one wait state
`timescale 1ns/100ps
module fdd_top_tb;
    import fdd_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic dl_done, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    fdd_dl_req_type dl_req;
    int bad_count, check_count;

    fdd_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dl_req(dl_req), .dl_done(dl_done), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; waits for pready, only the watchdog ends a dead wait
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic launch(input logic [7:0] key, input logic [7:0] dest);
        apb(1'b1, 12'h004, {24'h0, key});
        apb(1'b1, 12'h000, {24'h0, dest});
        apb(1'b1, 12'h008, 32'h00000001);
    endtask

    task automatic t_reset();
        apb(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        launch(8'h5A, 8'h03);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdat, 32'h0);
        $display("reset and key test done");
    endtask

    // every legal code, with the done interrupt enabled
    task automatic t_map();
        logic [23:0] tbl [8] = '{24'hFF9000, 24'hFFA000, 24'hFFB000,
            24'hFFC000, 24'hFFD000, 24'hFFE000, 24'hFF8000, 24'hFF7000};
        int n;
        apb(1'b1, 12'h014, 32'h00000001);
        for (int c = 0; c < 8; c++) begin
            launch(8'hA5, 8'(c));
            n = 0;
            while (dl_req.valid !== 1'b1 && n < 20) begin
                @(posedge mclk);
                n++;
            end
            chk({8'h0, dl_req.addr}, {8'h0, tbl[c]});
            apb(1'b0, 12'h018, 32'h0);
            chk(rdat, {8'h0, tbl[c]});
            apb(1'b0, 12'h008, 32'h0);
            chk(rdat, 32'h00000001);
            dl_done <= 1'b1;
            @(posedge mclk);
            dl_done <= 1'b0;
            apb(1'b0, 12'h00C, 32'h0);
            chk({rdat[30:0], irq}, 32'h00000003);
            apb(1'b1, 12'h010, 32'h00000003);
            apb(1'b0, 12'h00C, 32'h0);
            chk({rdat[30:0], irq}, 32'h0);
        end
        $display("address map test done");
    endtask

    // codes above seven abort; error interrupt stays masked
    task automatic t_bad();
        logic [7:0] codes [2] = '{8'h08, 8'h7F};
        foreach (codes[i]) begin
            launch(8'hA5, codes[i]);
            apb(1'b0, 12'h000, 32'h0);
            chk(rdat, {24'h0, 1'b1, codes[i][6:0]});
            apb(1'b0, 12'h00C, 32'h0);
            chk({rdat[30:0], irq}, 32'h00000004);
            apb(1'b1, 12'h010, 32'h00000003);
        end
        $display("bad code test done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, dl_done} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_map();
        t_bad();
        print_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        print_verdict();
    end
endmodule
